/* mfr_pkg.sv */
/*
 Package for the multifunction terminal routing block: routing codes,
 field widths and reset values.
 Assumes a single 20 MHz clock domain; no bus, all controls are ports.
*/
package mfr_pkg;

   // ----------------------------------------------------------------
   // Routing field
   // ----------------------------------------------------------------
   localparam int unsigned SEL_W    = 4;
   localparam int unsigned NPINS    = 7;
   localparam int unsigned NGPIO    = 5;
   localparam int unsigned NIRQ     = 16;
   localparam int unsigned IRQ_W    = 4;

   // Function codes shared by every shared pin
   localparam logic [3:0] FN_IRQ      = 4'h0;  // Parallel interrupt request
   localparam logic [3:0] FN_INTA     = 4'h1;
   localparam logic [3:0] FN_GPI      = 4'h2;
   localparam logic [3:0] FN_GPO      = 4'h3;
   localparam logic [3:0] FN_LED      = 4'h4;
   localparam logic [3:0] FN_VIDEO    = 4'h5;
   localparam logic [3:0] FN_AUDIO    = 4'h6;
   localparam logic [3:0] FN_PWREVT   = 4'h7;
   localparam logic [3:0] FN_D3       = 4'h8;
   localparam logic [3:0] FN_RING     = 4'h9;
   localparam logic [3:0] FN_SERIRQ   = 4'ha;
   localparam logic [3:0] FN_LOCK     = 4'hb;
   localparam logic [3:0] FN_CLKRUN   = 4'hc;

   // Routing reset values, pin 3 defaults to serialized interrupt
   localparam logic [27:0] ROUTE_RST  = 28'h000a000;

   // Loader state encoding width
   localparam int unsigned LDR_W      = 2;

endpackage : mfr_pkg

/* mfr_pin_cell.sv */
/*
 One shared pin cell: decodes the routing code into drive value and
 output enable (active low), and reports whether the code is legal.
 Assumes the caller supplies the legal-function mask of this pin.
*/
`timescale 1ns/1ns
`default_nettype none
module mfr_pin_cell (
   input  wire logic [3:0]  sel,
   input  wire logic [15:0] legal,
   input  wire logic        irq_val,
   input  wire logic        inta_n,
   input  wire logic        gpo_val,
   input  wire logic        led_val,
   input  wire logic        video_val,
   input  wire logic        audio_val,
   input  wire logic        pwr_event_n,
   input  wire logic        d3_val,
   input  wire logic        ring_val,
   input  wire logic        serirq_o,
   input  wire logic        serirq_oe_n,
   input  wire logic        clkrun_o,
   input  wire logic        clkrun_oe_n,
   output logic             pin_o,
   output logic             pin_oe_n,
   output logic             is_legal
);

   // ----------------------------------------------------------------
   // Function decode
   // ----------------------------------------------------------------
   // Inputs and illegal codes leave the pin undriven
   always_comb begin
      pin_o    = 1'b0;
      pin_oe_n = 1'b1;
      is_legal = legal[sel];
      if (is_legal) begin
         unique case (sel)
            mfr_pkg::FN_IRQ:    begin pin_o = irq_val;   pin_oe_n = 1'b0; end
            mfr_pkg::FN_INTA:   begin pin_o = 1'b0;      pin_oe_n = inta_n; end
            mfr_pkg::FN_GPO:    begin pin_o = gpo_val;   pin_oe_n = 1'b0; end
            mfr_pkg::FN_LED:    begin pin_o = led_val;   pin_oe_n = 1'b0; end
            mfr_pkg::FN_VIDEO:  begin pin_o = video_val; pin_oe_n = 1'b0; end
            mfr_pkg::FN_AUDIO:  begin pin_o = audio_val; pin_oe_n = 1'b0; end
            mfr_pkg::FN_PWREVT: begin pin_o = 1'b0;      pin_oe_n = pwr_event_n; end
            mfr_pkg::FN_D3:     begin pin_o = d3_val;    pin_oe_n = 1'b0; end
            mfr_pkg::FN_RING:   begin pin_o = ring_val;  pin_oe_n = 1'b0; end
            mfr_pkg::FN_SERIRQ: begin pin_o = serirq_o;  pin_oe_n = serirq_oe_n; end
            mfr_pkg::FN_CLKRUN: begin pin_o = clkrun_o;  pin_oe_n = clkrun_oe_n; end
            default:            begin pin_o = 1'b0;      pin_oe_n = 1'b1; end  // GPI, LOCK: inputs
         endcase
      end
   end

endmodule : mfr_pin_cell
`default_nettype wire

/* mfr_routing.sv */
/*
 Multifunction terminal routing: seven shared pins, serial-loader pin
 takeover, speaker XOR, ring/power-event output, suspend protection.
 Assumes all inputs synchronous to clk; a separate loader engine drives
 the serial data/clock values and reports completion.
*/
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Pin 0 routes INTA, input 0, output 0, LED, video, audio, power event or IRQ.
// - Pin 1 routes input 1, output 1, LED, low-power, video, audio, power event, IRQ.
// - Pin 2 adds ring-indicate to the usual set of pin 1, with input 2 and output 2.
// - Pin 3 is IRQ or serialized interrupt, the latter after reset.
// - Pin 4 routes LOCK, input 3, output 3 and the usual set with ring.
// - Pin 5 routes input 4, output 4, LED, video, audio, low-power, power event, IRQ.
// - Pin 6 is clock-run handshake or parallel IRQ.
// - Both detects high after global reset make pin 1 the serial data line.
// - Both detects high after global reset make pin 4 the serial clock.
// - With serial enabled, defaults load from EEPROM after global reset.
// - Speaker out is the XOR of all card speaker/audio inputs.
// - Suspend keeps the routing register from clearing on global or PCI reset; the serial detect and loader still clear on global reset.
// - A dedicated output carries ring-indicate or power-event.
module mfr_routing #(
   parameter int unsigned NSOCK = 2
) (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  global_reset_input_n,
   input  wire logic                  pci_reset_input_n,
   input  wire logic                  suspend,
   input  wire logic                  serial_detect_a,
   input  wire logic                  serial_detect_b,
   input  wire logic                  route_we,
   input  wire logic [27:0]           route_wdata,
   output logic      [27:0]           route_rdata,
   output logic      [6:0]            route_illegal,
   input  wire logic [3:0]            irq_sel,
   input  wire logic [15:0]           irq_lines,
   input  wire logic                  inta_n,
   input  wire logic [4:0]            gpo_data,
   output logic      [4:0]            gpi_data,
   input  wire logic                  activity_led,
   input  wire logic                  video_port_switch,
   input  wire logic                  card_audio_pwm,
   input  wire logic                  general_power_event_n,
   input  wire logic                  low_power_state_status,
   input  wire logic                  ring_indicate,
   input  wire logic                  pme_n,
   input  wire logic                  ring_not_pme,
   input  wire logic                  serirq_o,
   input  wire logic                  serirq_oe_n,
   output logic                       serirq_i,
   input  wire logic                  clkrun_o,
   input  wire logic                  clkrun_oe_n,
   output logic                       clkrun_i,
   output logic                       lock_i,
   input  wire logic                  serial_data_o,
   input  wire logic                  serial_data_oe_n,
   input  wire logic                  serial_clock_o,
   input  wire logic                  serial_clock_oe_n,
   output logic                       serial_data_i,
   input  wire logic                  eeprom_load_done,
   output logic                       serial_enabled,
   output logic                       eeprom_load_start,
   output logic                       eeprom_loading,
   input  wire logic [6:0]            shared_pin_i,
   output logic      [6:0]            shared_pin_o,
   output logic      [6:0]            shared_pin_oe_n,
   input  wire logic [NSOCK-1:0]      card_speaker_input,
   output logic                       speaker_out_to_host,
   output logic                       ring_indicate_output
);

   // ----------------------------------------------------------------
   // Types and functions
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MFR_IDLE = 2'b00,
      MFR_LOAD = 2'b01,
      MFR_DONE = 2'b11
   } mfr_ldr_t;

   // Bit mask of one function code
   function automatic logic [15:0] mfr_fn(input logic [3:0] code);
      mfr_fn = 16'h0001 << code;
   endfunction : mfr_fn

   // Legal functions per pin
   localparam logic [15:0] LEGAL0 = mfr_fn(mfr_pkg::FN_INTA) | mfr_fn(mfr_pkg::FN_GPI)
      | mfr_fn(mfr_pkg::FN_GPO) | mfr_fn(mfr_pkg::FN_LED) | mfr_fn(mfr_pkg::FN_VIDEO)
      | mfr_fn(mfr_pkg::FN_AUDIO) | mfr_fn(mfr_pkg::FN_PWREVT) | mfr_fn(mfr_pkg::FN_IRQ);
   localparam logic [15:0] LEGAL1 = mfr_fn(mfr_pkg::FN_GPI) | mfr_fn(mfr_pkg::FN_GPO)
      | mfr_fn(mfr_pkg::FN_LED) | mfr_fn(mfr_pkg::FN_D3) | mfr_fn(mfr_pkg::FN_VIDEO)
      | mfr_fn(mfr_pkg::FN_AUDIO) | mfr_fn(mfr_pkg::FN_PWREVT) | mfr_fn(mfr_pkg::FN_IRQ);
   localparam logic [15:0] LEGAL2 = LEGAL1 | mfr_fn(mfr_pkg::FN_RING);
   localparam logic [15:0] LEGAL3 = mfr_fn(mfr_pkg::FN_IRQ) | mfr_fn(mfr_pkg::FN_SERIRQ);
   localparam logic [15:0] LEGAL4 = LEGAL2 | mfr_fn(mfr_pkg::FN_LOCK);
   localparam logic [15:0] LEGAL5 = LEGAL1;
   localparam logic [15:0] LEGAL6 = mfr_fn(mfr_pkg::FN_IRQ) | mfr_fn(mfr_pkg::FN_CLKRUN);
   localparam logic [15:0] LEGAL [7] = '{LEGAL0, LEGAL1, LEGAL2, LEGAL3, LEGAL4, LEGAL5, LEGAL6};

   // General I/O index carried by each pin (pins 3 and 6 have none)
   localparam int unsigned GPIO_IDX [7] = '{0, 1, 2, 0, 3, 4, 0};

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [27:0] route_reg;
   logic [3:0]  sel       [7];
   logic [6:0]  cell_o;
   logic [6:0]  cell_oe_n;
   logic [6:0]  cell_legal;
   logic        clear_req;
   logic        greset_prev_reg;
   logic        serial_reg;
   mfr_ldr_t    ldr_reg;
   logic        irq_val;
   logic        ring_val;

   // Routing register clears on either reset unless suspend shields it
   assign clear_req = (!global_reset_input_n || !pci_reset_input_n) && !suspend;

   // ----------------------------------------------------------------
   // Routing register
   // ----------------------------------------------------------------
   // One 4-bit field per pin, all seven written together
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         route_reg <= mfr_pkg::ROUTE_RST;
      end else if (clear_req) begin
         route_reg <= mfr_pkg::ROUTE_RST;
      end else if (route_we) begin
         route_reg <= route_wdata;
      end
   end

   assign route_rdata = route_reg;

   // ----------------------------------------------------------------
   // Serial loader detect and sequence
   // ----------------------------------------------------------------
   // Track global reset to find its release edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         greset_prev_reg <= 1'b0;
      end else begin
         greset_prev_reg <= global_reset_input_n;
      end
   end

   // Detect straps caught at global reset release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         serial_reg <= 1'b0;
      end else if (!global_reset_input_n) begin
         serial_reg <= 1'b0;
      end else if (!greset_prev_reg) begin
         serial_reg <= serial_detect_a && serial_detect_b;
      end
   end

   // Loader sequence: start once after release, wait for done
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ldr_reg <= MFR_IDLE;
      end else if (!global_reset_input_n) begin
         ldr_reg <= MFR_IDLE;
      end else begin
         unique case (ldr_reg)
            MFR_IDLE: if (serial_reg) ldr_reg <= MFR_LOAD;
            MFR_LOAD: if (eeprom_load_done) ldr_reg <= MFR_DONE;
            MFR_DONE: ldr_reg <= MFR_DONE;
            default:  ldr_reg <= MFR_IDLE;
         endcase
      end
   end

   assign serial_enabled    = serial_reg;
   assign eeprom_load_start = (ldr_reg == MFR_IDLE) && serial_reg;
   assign eeprom_loading    = (ldr_reg == MFR_LOAD);

   // ----------------------------------------------------------------
   // Pin cells
   // ----------------------------------------------------------------
   assign irq_val  = irq_lines[irq_sel];
   assign ring_val = ring_not_pme ? ring_indicate : 1'b0;

   for (genvar p = 0; p < 7; p++) begin : g_pin
      assign sel[p] = route_reg[4*p +: 4];
      mfr_pin_cell u_cell (
         .sel         (sel[p]),
         .legal       (LEGAL[p]),
         .irq_val     (irq_val),
         .inta_n      (inta_n),
         .gpo_val     (gpo_data[GPIO_IDX[p]]),
         .led_val     (activity_led),
         .video_val   (video_port_switch),
         .audio_val   (card_audio_pwm),
         .pwr_event_n (general_power_event_n),
         .d3_val      (low_power_state_status),
         .ring_val    (ring_val),
         .serirq_o    (serirq_o),
         .serirq_oe_n (serirq_oe_n),
         .clkrun_o    (clkrun_o),
         .clkrun_oe_n (clkrun_oe_n),
         .pin_o       (cell_o[p]),
         .pin_oe_n    (cell_oe_n[p]),
         .is_legal    (cell_legal[p])
      );
   end

   assign route_illegal = ~cell_legal;

   // Serial loader takes pins 1 and 4 over the routing choice
   always_comb begin
      shared_pin_o    = cell_o;
      shared_pin_oe_n = cell_oe_n;
      if (serial_reg) begin
         shared_pin_o[1]    = serial_data_o;
         shared_pin_oe_n[1] = serial_data_oe_n;
         shared_pin_o[4]    = serial_clock_o;
         shared_pin_oe_n[4] = serial_clock_oe_n;
      end
   end

   // ----------------------------------------------------------------
   // Input capture
   // ----------------------------------------------------------------
   // General inputs registered from pins routed as inputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gpi_data <= 5'h00;
      end else begin
         for (int p = 0; p < 7; p++) begin
            if (sel[p] == mfr_pkg::FN_GPI && cell_legal[p]) begin
               gpi_data[GPIO_IDX[p]] <= shared_pin_i[p];
            end
         end
      end
   end

   assign serirq_i      = shared_pin_i[3];
   assign clkrun_i      = shared_pin_i[6];
   assign lock_i        = shared_pin_i[4];
   assign serial_data_i = shared_pin_i[1];

   // ----------------------------------------------------------------
   // Fixed outputs
   // ----------------------------------------------------------------
   // Speaker is the XOR of all card audio inputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         speaker_out_to_host <= 1'b0;
      end else begin
         speaker_out_to_host <= ^card_speaker_input;
      end
   end

   // Ring indicate or power-management event on one pin
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ring_indicate_output <= 1'b0;
      end else begin
         ring_indicate_output <= ring_not_pme ? ring_indicate : !pme_n;
      end
   end

endmodule : mfr_routing
`default_nettype wire

/* mfr_routing_asserts.sv */
/*
 Checker for the routing block: pin takeover, write, reset and speaker timing.
 Assumes it is bound to mfr_routing and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module mfr_routing_asserts #(
   parameter int unsigned NSOCK = 2
) (
   input wire logic             clk,
   input wire logic             nrst,
   input wire logic             global_reset_input_n,
   input wire logic             pci_reset_input_n,
   input wire logic             suspend,
   input wire logic             route_we,
   input wire logic [27:0]      route_wdata,
   input wire logic [27:0]      route_rdata,
   input wire logic [6:0]       route_illegal,
   input wire logic             serirq_o,
   input wire logic             serirq_oe_n,
   input wire logic             serial_data_oe_n,
   input wire logic             serial_clock_oe_n,
   input wire logic             serial_enabled,
   input wire logic             eeprom_load_start,
   input wire logic [6:0]       shared_pin_o,
   input wire logic [6:0]       shared_pin_oe_n,
   input wire logic [NSOCK-1:0] card_speaker_input,
   input wire logic             speaker_out_to_host
);
   // ----------------------------------------------------------------
   // Helpers and properties
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic clear;
   logic spk_xor;
   // Reset clear is active unless suspend shields the routing
   assign clear = (!global_reset_input_n || !pci_reset_input_n) && !suspend;
   assign spk_xor = ^card_speaker_input;

   route_write_a: assert property (route_we && !clear |=> route_rdata == $past(route_wdata))
      else $error("routing write not taken");
   reset_clear_a: assert property (clear |=> route_rdata == mfr_pkg::ROUTE_RST)
      else $error("routing not cleared");
   suspend_keep_a: assert property (suspend && !route_we |=> $stable(route_rdata))
      else $error("routing changed under suspend");
   illegal_off_a: assert property (!serial_enabled |-> (route_illegal & ~shared_pin_oe_n) == 7'h00)
      else $error("illegal pin driven");
   serirq_pin_a: assert property (route_rdata[15:12] == mfr_pkg::FN_SERIRQ |->
      shared_pin_oe_n[3] == serirq_oe_n && (serirq_oe_n || shared_pin_o[3] == serirq_o))
      else $error("pin 3 not serial interrupt");
   serial_pins_a: assert property (serial_enabled |-> shared_pin_oe_n[1] == serial_data_oe_n &&
      shared_pin_oe_n[4] == serial_clock_oe_n)
      else $error("serial pins not taken over");
   load_pulse_a: assert property ($rose(serial_enabled) |-> eeprom_load_start ##1 !eeprom_load_start)
      else $error("loader start not one cycle");
   speaker_xor_a: assert property ($past(nrst) |-> speaker_out_to_host == $past(spk_xor))
      else $error("speaker not xor of inputs");
endmodule : mfr_routing_asserts

bind mfr_routing mfr_routing_asserts #(.NSOCK(NSOCK)) chk (.clk(clk), .nrst(nrst),
   .global_reset_input_n(global_reset_input_n), .pci_reset_input_n(pci_reset_input_n), .suspend(suspend),
   .route_we(route_we), .route_wdata(route_wdata), .route_rdata(route_rdata), .route_illegal(route_illegal),
   .serirq_o(serirq_o), .serirq_oe_n(serirq_oe_n), .serial_data_oe_n(serial_data_oe_n),
   .serial_clock_oe_n(serial_clock_oe_n), .serial_enabled(serial_enabled),
   .eeprom_load_start(eeprom_load_start), .shared_pin_o(shared_pin_o), .shared_pin_oe_n(shared_pin_oe_n),
   .card_speaker_input(card_speaker_input), .speaker_out_to_host(speaker_out_to_host));
`default_nettype wire

/* mfr_host_model.sv */
/*
 Host side of the shared pins: resolves each wire from both drivers.
 Assumes active-low enables from the block and board pull-ups.
*/
`timescale 1ns/1ns
`default_nettype none
module mfr_host_model (
   input  wire logic [6:0] pin_o,
   input  wire logic [6:0] pin_oe_n,
   input  wire logic       host_en,
   input  wire logic [6:0] host_val,
   output logic      [6:0] pin_i
);
   // Block drive wins, host drives released pins, else pull-up
   always_comb begin
      for (int p = 0; p < 7; p++) begin
         pin_i[p] = !pin_oe_n[p] ? pin_o[p] : (host_en ? host_val[p] : 1'b1);
      end
   end
endmodule : mfr_host_model
`default_nettype wire

/* tb.sv */
/*
 Self-checking bench for the routing block.
 Assumes mfr_pkg, the host pin model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ----------------------------------------------------------------
   // Stimulus and wiring
   // ----------------------------------------------------------------
   logic clk = 0, nrst = 0, g_n = 1, p_n = 1, susp = 0, da = 0, db = 0, we = 0, done = 0, hen = 0;
   logic inta_n = 0, led = 1, vid = 1, aud = 1, pev_n = 0, d3 = 1, ring = 1, pme_n = 1, rnp = 1;
   logic [3:0] isel = 4'h5;
   logic sq_o = 1, sq_oe_n = 0, cr_o = 1, cr_oe_n = 0, sd_o = 1, sd_oe_n = 0, sc_o = 0, sc_oe_n = 0;
   logic [27:0] wd = 28'h0, rd;
   logic [4:0] gpo = 5'h0a, gpi;
   logic [1:0] spk = 2'h0;
   logic [6:0] ill, pi, po, poe_n;
   logic sq_i, cr_i, lk_i, sd_i, ser, lds, ldg, spo, rio;
   int miscompares = 0, comparisons = 0, cycles = 0;

   mfr_routing #(.NSOCK(2)) uut (.clk(clk), .nrst(nrst), .global_reset_input_n(g_n), .pci_reset_input_n(p_n),
      .suspend(susp), .serial_detect_a(da), .serial_detect_b(db), .route_we(we), .route_wdata(wd),
      .route_rdata(rd), .route_illegal(ill), .irq_sel(isel), .irq_lines(16'h0020), .inta_n(inta_n),
      .gpo_data(gpo), .gpi_data(gpi), .activity_led(led), .video_port_switch(vid), .card_audio_pwm(aud),
      .general_power_event_n(pev_n), .low_power_state_status(d3), .ring_indicate(ring), .pme_n(pme_n),
      .ring_not_pme(rnp), .serirq_o(sq_o), .serirq_oe_n(sq_oe_n), .serirq_i(sq_i), .clkrun_o(cr_o),
      .clkrun_oe_n(cr_oe_n), .clkrun_i(cr_i), .lock_i(lk_i), .serial_data_o(sd_o), .serial_data_oe_n(sd_oe_n),
      .serial_clock_o(sc_o), .serial_clock_oe_n(sc_oe_n), .serial_data_i(sd_i), .eeprom_load_done(done),
      .serial_enabled(ser), .eeprom_load_start(lds), .eeprom_loading(ldg), .shared_pin_i(pi),
      .shared_pin_o(po), .shared_pin_oe_n(poe_n), .card_speaker_input(spk), .speaker_out_to_host(spo),
      .ring_indicate_output(rio));
   mfr_host_model host (.pin_o(po), .pin_oe_n(poe_n), .host_en(hen), .host_val(7'h2d), .pin_i(pi));

   // Clock and hang guard
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [27:0] e, input logic [27:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [27:0] v);
      @(negedge clk);
      we = 1'b1;
      wd = v;
      @(negedge clk);
      we = 1'b0;
   endtask : wr
   task automatic results;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      chk("route", mfr_pkg::ROUTE_RST, rd);
      chk("irq pins", 28'h0037, 28'({poe_n & 7'h37, po & 7'h37}));
      chk("pin3", 28'h1, 28'({poe_n[3], po[3]}));
      isel = 4'h4;
      @(negedge clk);
      chk("irq pick", 28'h0000, 28'({poe_n & 7'h37, po & 7'h37}));
   endtask : t_reset
   task automatic t_legal;
      logic [15:0] lg [7] = '{16'h00ff, 16'h01fd, 16'h03fd, 16'h0401, 16'h0bfd, 16'h01fd, 16'h1001};
      logic [6:0] e;
      for (int c = 0; c < 16; c++) begin
         wr({7{c[3:0]}});
         for (int p = 0; p < 7; p++) begin
            e[p] = !lg[p][c];
         end
         chk("illegal", 28'(e), 28'(ill));
      end
   endtask : t_legal
   task automatic t_drive;
      wr(28'hc69a841);
      chk("src a", 28'h0076, 28'({poe_n & 7'h77, po & 7'h77}));
      wr(28'hc48a657);
      chk("src b", 28'h0076, 28'({poe_n & 7'h77, po & 7'h77}));
      wr(28'hc33a333);
      chk("gpo", 28'h0052, 28'({poe_n & 7'h77, po & 7'h77}));
      wr(28'hc22a222);
      hen = 1'b1;
      repeat (2) @(negedge clk);
      chk("gpi float", 28'h37, 28'(poe_n & 7'h37));
      chk("gpi", 28'h15, 28'(gpi));
      chk("pin inputs", 28'hc, 28'({sq_i, cr_i, lk_i, sd_i}));
      hen = 1'b0;
   endtask : t_drive
   task automatic t_audio;
      for (int i = 0; i < 8; i++) begin
         spk = i[1:0];
         {rnp, ring, pme_n} = i[2:0];
         @(negedge clk);
         chk("speaker", 28'(^i[1:0]), 28'(spo));
         chk("ring out", 28'(i[2] ? i[1] : !i[0]), 28'(rio));
      end
   endtask : t_audio
   task automatic t_suspend;
      wr(28'h5a55555);
      susp = 1'b1;
      g_n = 1'b0;
      p_n = 1'b0;
      repeat (3) @(negedge clk);
      chk("kept", 28'h5a55555, rd);
      susp = 1'b0;
      @(negedge clk);
      chk("cleared", mfr_pkg::ROUTE_RST, rd);
      g_n = 1'b1;
      p_n = 1'b1;
   endtask : t_suspend
   task automatic t_serial(input logic a, input logic b);
      int n = 0;
      @(negedge clk);
      da = a;
      db = b;
      g_n = 1'b0;
      @(negedge clk);
      g_n = 1'b1;
      while (lds !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      chk("serial on", 28'(a & b), 28'(ser));
      if (a & b) begin
         chk("serial pins", 28'h1, 28'({poe_n[4], po[4], poe_n[1], po[1]}));
         @(negedge clk);
         chk("loading", 28'h1, 28'(ldg));
         done = 1'b1;
         @(negedge clk);
         done = 1'b0;
         @(negedge clk);
         chk("load end", 28'h0, 28'(ldg));
      end
   endtask : t_serial

   // Main sequence
   initial begin
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      t_reset();
      t_legal();
      t_drive();
      t_audio();
      t_suspend();
      t_serial(1'b1, 1'b0);
      t_serial(1'b1, 1'b1);
      results();
   end
endmodule : tb
`default_nettype wire
